// File: design/regbank.v
// Register bank showing each field access type on a simple word bus.
// Assumes a single-cycle bus master and synchronous hardware event inputs.
`timescale 1ns/1ns
`include "regbank_defines.vh"

// Functional notes
// RULE1: Clear-on-read field clears after being read
// RULE2: Software writes reset value to read-only fields
// RULE3: W1C readable: one clears, zero keeps
// RULE4: Write back read value to acknowledge status
// RULE5: W1S readable: one sets, zero keeps
// RULE6: Write-only W1C: one clears, reads meaningless
// RULE7: Write-only W1C clears interrupt status bits
// RULE8: Reserved bits read back as zero
// RULE9: Software preserves reserved bits on RMW
// RULE10: Registers decoded at base plus offset
// RULE11: Write-only fields: only writes take effect
// RULE12: Fields take reset values after reset
// RULE13: Read/write field stores and returns value
module regbank #(
  parameter        WIDTH     = 32,
  parameter [31:0] BASE_ADDR = 32'h00000000
) (
  input  wire             sys_clk,
  input  wire             sys_rst,
  input  wire [31:0]      bus_addr,
  input  wire             bus_wr,
  input  wire             bus_rd,
  input  wire [WIDTH-1:0] bus_wdata,
  output reg  [WIDTH-1:0] bus_rdata,
  output wire             bus_err,
  input  wire [WIDTH-1:0] hw_status_set,
  input  wire [WIDTH-1:0] hw_event_set,
  output wire [WIDTH-1:0] ctrl_out,
  output wire [WIDTH-1:0] set_out,
  output wire [WIDTH-1:0] status_out
);

  // Constants at bus width
  localparam [WIDTH-1:0] rst_ctrl_val   = `RST_CTRL;
  localparam [WIDTH-1:0] rst_status_val = `RST_STATUS;
  localparam [WIDTH-1:0] rst_event_val  = `RST_EVENT;
  localparam [WIDTH-1:0] rst_set_val    = `RST_SET;
  localparam [WIDTH-1:0] rst_rdata_val  = `READ_ZERO;
  localparam [WIDTH-1:0] id_val         = `ID_VALUE;
  localparam [WIDTH-1:0] zero_val       = `READ_ZERO;

  // Field storage and next values
  reg  [WIDTH-1:0] ctrl_reg;
  reg  [WIDTH-1:0] status_reg;
  reg  [WIDTH-1:0] event_reg;
  reg  [WIDTH-1:0] set_reg;
  reg  [WIDTH-1:0] rdata_next;
  wire [WIDTH-1:0] ctrl_next;
  wire [WIDTH-1:0] status_next;
  wire [WIDTH-1:0] event_next;
  wire [WIDTH-1:0] set_next;
  wire [WIDTH-1:0] status_clr;
  wire [WIDTH-1:0] set_mask;

  // Decode and qualified strobes
  wire [31:0]      offset;
  wire             sel_ctrl;
  wire             sel_status;
  wire             sel_event;
  wire             sel_set;
  wire             sel_clear;
  wire             sel_id;
  wire             sel_any;
  wire             strobe_any;
  wire             wr_ctrl;
  wire             wr_status;
  wire             wr_set;
  wire             wr_clear;
  wire             wr_status_any;
  wire             rd_event;

  // Address decode relative to the module base
  assign offset     = bus_addr - BASE_ADDR; // [RULE10]
  assign sel_ctrl   = (offset == `OFF_CTRL); // [RULE10]
  assign sel_status = (offset == `OFF_STATUS);
  assign sel_event  = (offset == `OFF_EVENT);
  assign sel_set    = (offset == `OFF_SET);
  assign sel_clear  = (offset == `OFF_CLEAR);
  assign sel_id     = (offset == `OFF_ID);
  assign sel_any    = sel_ctrl || sel_status ||
                      sel_event || sel_set ||
                      sel_clear || sel_id;

  // Strobes
  assign strobe_any    = bus_wr || bus_rd;
  assign wr_ctrl       = bus_wr && sel_ctrl;
  assign wr_status     = bus_wr && sel_status;
  assign wr_set        = bus_wr && sel_set;
  assign wr_clear      = bus_wr && sel_clear;
  assign wr_status_any = wr_status || wr_clear;
  assign rd_event      = bus_rd && sel_event;
  assign bus_err       = strobe_any && !sel_any; // [RULE10]

  // Outputs from flip-flops
  assign ctrl_out   = ctrl_reg;
  assign set_out    = set_reg;
  assign status_out = status_reg;

  // Whole-word write masks
  assign ctrl_next  = wr_ctrl ? bus_wdata : ctrl_reg; // [RULE13]
  assign status_clr = wr_status_any ?
                      bus_wdata : zero_val; // [RULE3] [RULE6] [RULE7] [RULE11]
  assign set_mask   = wr_set ? bus_wdata : zero_val; // [RULE5]

  // Per-bit next values
  genvar i;

  // Status: hardware set beats a software clear
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_status
      assign status_next[i] = hw_status_set[i] | (status_reg[i] & ~status_clr[i]); // [RULE4]
    end
  endgenerate

  // Event: cleared by a read unless set again
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_event
      assign event_next[i] = hw_event_set[i] | (event_reg[i] & ~rd_event); // [RULE1]
    end
  endgenerate

  // Set-only field
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_set
      assign set_next[i] = set_reg[i] | set_mask[i]; // [RULE5]
    end
  endgenerate

  // Read/write field
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= rst_ctrl_val; // [RULE12]
    end
    else
    begin
      ctrl_reg <= ctrl_next; // [RULE13]
    end
  end

  // Status field
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      status_reg <= rst_status_val; // [RULE12]
    end
    else
    begin
      status_reg <= status_next; // [RULE3]
    end
  end

  // Clear-on-read field
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      event_reg <= rst_event_val; // [RULE12]
    end
    else
    begin
      event_reg <= event_next; // [RULE1]
    end
  end

  // Write-one-to-set field
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      set_reg <= rst_set_val; // [RULE12]
    end
    else
    begin
      set_reg <= set_next; // [RULE5]
    end
  end

  // Registered read data
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bus_rdata <= rst_rdata_val;
    end
    else
    begin
      bus_rdata <= rdata_next;
    end
  end

  // Read mux
  always @*
  begin
    rdata_next = zero_val; // [RULE8]
    if (bus_rd)
    begin
      case (offset)
        `OFF_CTRL:   rdata_next = ctrl_reg; // [RULE13]
        `OFF_STATUS: rdata_next = status_reg; // [RULE3]
        `OFF_EVENT:  rdata_next = event_reg; // [RULE1]
        `OFF_SET:    rdata_next = set_reg; // [RULE5]
        `OFF_CLEAR:  rdata_next = zero_val; // [RULE6] [RULE11]
        `OFF_ID:     rdata_next = id_val;
        default:     rdata_next = zero_val; // [RULE8]
      endcase
    end
  end

endmodule

// File: design/regbank_defines.vh
// Constants for the register field access-type bank.
// Assumes inclusion by regbank.v only.
`ifndef REGBANK_DEFINES_VH
`define REGBANK_DEFINES_VH
`define OFF_CTRL      32'h00000000
`define OFF_STATUS    32'h00000004
`define OFF_EVENT     32'h00000008
`define OFF_SET       32'h0000000c
`define OFF_CLEAR     32'h00000010
`define OFF_ID        32'h00000014
`define RST_CTRL      32'h00000000
`define RST_STATUS    32'h00000000
`define RST_EVENT     32'h00000000
`define RST_SET       32'h00000000
`define ID_VALUE      32'h00a5c3e1
`define READ_ZERO     32'h00000000
`endif

// File: verif/regbank_asserts.sv
// Port assertions for regbank.
// Assumes WIDTH 32 and bind by port name.
`timescale 1ns/1ns
module regbank_asserts #(parameter [31:0] BASE_ADDR = 32'h0) (
  input wire        sys_clk, sys_rst, bus_wr, bus_rd, bus_err,
  input wire [31:0] bus_addr, bus_wdata, bus_rdata, hw_status_set, hw_event_set,
  input wire [31:0] ctrl_out, set_out, status_out
);
  wire [31:0] a = bus_addr - BASE_ADDR;
  wire [31:0] clr = status_out & ~bus_wdata | hw_status_set;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_reset_clears: assert property (disable iff (1'b0) sys_rst |=>
    !(ctrl_out | set_out | status_out | bus_rdata)) else $error("reset");
  a_ctrl_write: assert property (bus_wr && a == 0 |=> ctrl_out == $past(bus_wdata))
    else $error("ctrl");
  a_ctrl_read: assert property (bus_rd && a == 0 |=> bus_rdata == $past(ctrl_out))
    else $error("ctrl rd");
  a_status_w1c: assert property (bus_wr && a == 4 |=> status_out == $past(clr))
    else $error("w1c");
  a_clear_wo: assert property (bus_wr && a == 16 |=> status_out == $past(clr))
    else $error("clear");
  a_clear_reads_zero: assert property (bus_rd && a == 16 |=> bus_rdata == 0)
    else $error("clear rd");
  a_set_w1s: assert property (bus_wr && a == 12 |=> set_out == $past(set_out | bus_wdata))
    else $error("w1s");
  a_event_rc: assert property (bus_rd && a == 8 && !hw_event_set ##1 !hw_event_set ##1
    bus_rd && a == 8 && !hw_event_set |=> bus_rdata == 0) else $error("rc");
  a_unmapped_err: assert property ((bus_wr || bus_rd) && a >= 24 && a < 256 |-> bus_err)
    else $error("decode");
endmodule
bind regbank regbank_asserts #(.BASE_ADDR(BASE_ADDR)) u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_err(bus_err), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .hw_status_set(hw_status_set), .hw_event_set(hw_event_set),
  .ctrl_out(ctrl_out), .set_out(set_out), .status_out(status_out));

// File: verif/regbank_test.sv
// Self-checking bench for regbank.
// Assumes the design offsets and a nonzero base.
`timescale 1ns/1ns
module register_field_access_types_test;
  localparam [31:0] B = 32'h40000000;
  reg         sys_clk = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0, e;
  reg  [31:0] bus_addr = 0, bus_wdata = 0, hw_status_set = 0, hw_event_set = 0;
  wire [31:0] bus_rdata, ctrl_out, set_out, status_out;
  wire        bus_err;
  integer     n_mismatch = 0, total_checks = 0;
  regbank #(.BASE_ADDR(B)) i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_err(bus_err),
    .hw_status_set(hw_status_set), .hw_event_set(hw_event_set),
    .ctrl_out(ctrl_out), .set_out(set_out), .status_out(status_out));
  initial forever #5 sys_clk = ~sys_clk;
  task chk(input [31:0] s, x);
    begin
      total_checks = total_checks + 1;
      if (s !== x)
      begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: %h vs %h", $time, s, x);
      end
    end
  endtask
  task acc(input w, input [31:0] ad, d);
    begin
      @(negedge sys_clk);
      {bus_wr, bus_rd, bus_addr, bus_wdata} = {w, !w, ad, d};
      #1 e = bus_err;
      @(negedge sys_clk);
      {bus_wr, bus_rd} = 2'b00;
    end
  endtask
  task rd(input [31:0] ad, x);
    begin
      acc(0, ad, 0);
      chk(bus_rdata, x);
    end
  endtask
  task hw(input [31:0] s, v);
    begin
      @(negedge sys_clk);
      {hw_status_set, hw_event_set} = {s, v};
      @(negedge sys_clk);
      {hw_status_set, hw_event_set} = 64'h0;
    end
  endtask
  task t_regs;
    begin
      chk(ctrl_out | set_out | status_out | bus_rdata, 32'h0);
      acc(1, B, 32'ha5a50f0f);
      rd(B, 32'ha5a50f0f);
      chk({31'h0, e}, 32'h0);
      acc(1, B, 32'ha5a50f0e);
      rd(B, 32'ha5a50f0e);
      acc(1, B + 32'h14, 32'h00a5c3e1);
      rd(B + 32'h14, 32'h00a5c3e1);
      acc(1, B + 32'hc, 32'h1);
      acc(1, B + 32'hc, 32'h2);
      acc(1, B + 32'hc, 32'h0);
      chk(set_out, 32'h3);
    end
  endtask
  task t_status;
    begin
      hw(32'h5, 32'h30);
      rd(B + 32'h4, 32'h5);
      hw(32'h8, 32'h0);
      acc(1, B + 32'h4, 32'h5);
      chk(status_out, 32'h8);
      acc(1, B + 32'h10, 32'h8);
      chk(status_out, 32'h0);
      rd(B + 32'h10, 32'h0);
      rd(B + 32'h8, 32'h30);
      rd(B + 32'h8, 32'h0);
      rd(B + 32'h40, 32'h0);
      chk({31'h0, e}, 32'h1);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    repeat (2) @(negedge sys_clk);
    sys_rst = 0;
    t_regs;
    t_status;
    complete_run;
  end
endmodule
